// >>> src/mdu_pkg.sv
package product_quotient_pkg;
	localparam int DATA_W = 32;
	localparam int ACC_W = 64;
	localparam int HALF_W = 16;
	localparam int FIT_8 = 8;
	localparam int FIT_24 = 24;
	localparam int MCAND_W = 33;
	localparam int MPLIER_W = 17;
	localparam int PROD_W = MCAND_W + MPLIER_W;
	localparam int DEST_W = 5;
	localparam int CNT_W = 6;
	localparam logic [CNT_W-1:0] ITER_FULL = 6'h20;
	localparam logic [CNT_W-1:0] CNT_ONE = 6'h01;
	localparam logic [CNT_W-1:0] CNT_ZERO = 6'h00;
	// Skipped iterations per dividend class: 8, 16, 24, 32 bits
	localparam logic [CNT_W-1:0] DIV_SKIP [4] = '{6'h17, 6'h0F, 6'h07, 6'h00};
	// Busy cycles per dividend class
	localparam logic [CNT_W-1:0] DIV_REP [4] = '{6'h0B, 6'h12, 6'h19, 6'h20};
	localparam logic [1:0] CLASS_8 = 2'h0;
	localparam logic [1:0] CLASS_16 = 2'h1;
	localparam logic [1:0] CLASS_24 = 2'h2;
	localparam logic [1:0] CLASS_32 = 2'h3;

	typedef enum logic [3:0] {
		op_none,
		op_prod_acc,
		op_prod_acc_u,
		op_prod_accum,
		op_prod_accum_u,
		op_prod_sub,
		op_prod_sub_u,
		op_prod_gpr,
		op_quot,
		op_quot_u,
		op_move_upper,
		op_move_bottom
	} op_t;

	typedef struct packed {
		op_t op;
		logic [DATA_W-1:0] left;
		logic [DATA_W-1:0] right;
		logic [DEST_W-1:0] dest;
	} issue_t;

	typedef struct packed {
		logic valid;
		logic [DEST_W-1:0] dest;
		logic [DATA_W-1:0] data;
	} gpr_wr_t;
endpackage : product_quotient_pkg

// >>> src/booth_array.sv
`timescale 1ns/1ps
`default_nettype none
module booth_array #(
	parameter int AW = 33,
	parameter int BW = 17
) (
	input wire logic signed [AW-1:0] i_mcand,
	input wire logic signed [BW-1:0] i_mplier,
	output logic signed [AW+BW-1:0] o_product
);
	localparam int ND = (BW + 1) / 2;
	localparam int PW = AW + BW;

	function automatic logic signed [AW:0] booth_pp(input logic [2:0] t,
			input logic signed [AW-1:0] x);
		logic signed [AW:0] xe;
		xe = {x[AW-1], x};
		case (t)
			3'h1, 3'h2: booth_pp = xe;
			3'h3: booth_pp = xe <<< 1;
			3'h4: booth_pp = -(xe <<< 1);
			3'h5, 3'h6: booth_pp = -xe;
			default: booth_pp = '0;
		endcase
	endfunction : booth_pp

	logic [2*ND:0] ext;
	logic signed [PW-1:0] pp [ND];

	assign ext = {{(2*ND-BW){i_mplier[BW-1]}}, i_mplier, 1'b0};

	// Radix-4 recoded partial products
	for (genvar g = 0; g < ND; g++) begin : g_pp
		logic signed [AW:0] raw;
		assign raw = booth_pp(ext[2*g+2 -: 3], i_mcand);
		assign pp[g] = PW'({{(PW-AW-1){raw[AW]}}, raw} <<< (2 * g));
	end

	always_comb begin
		o_product = '0;
		for (int k = 0; k < ND; k++) begin
			o_product = o_product + pp[k];
		end
	end
endmodule : booth_array
`default_nettype wire

// >>> src/product_quotient_unit.sv
// Overview of operation
// - One 32x16 array; short right operand one pass, long right operand two passes.
// - Pass count depends only on right operand width, never the left.
// - Short or long path is picked by hardware from operand value.
// - Short multiply every cycle; long every second; back-to-back long stalls issue.
// - Unit pipeline runs on regardless of integer pipeline stalls.
// - Divide iterates one quotient bit per clock.
// - Dividend fitting 8/16/24 bits skips 23/15/7 iterations.
// - Any unit instruction during a running divide stalls until done.
// - Accumulator multiplies: latency/repeat 1/1 short, 2/2 long.
// - Register-target multiply writes low product bits; latency 2/3, repeat 1/2.
// - Divide latency 12/19/26/33, repeat 11/18/25/32 by dividend width.
// - Results except register-target multiply go to accumulator halves; move-from copies them to registers.
// - Accumulate adds product to pair; subtract removes product from pair.
// - Booth array: left operand is 32 dimension, right the 16.
`timescale 1ns/1ps
`default_nettype none
module product_quotient_unit import product_quotient_pkg::*; (
	input wire logic i_sys_clk,
	input wire logic i_rst,
	input wire logic i_issue_valid,
	input wire issue_t i_issue,
	output logic o_stall,
	output gpr_wr_t o_gpr_wr,
	output logic [DATA_W-1:0] o_acc_upper,
	output logic [DATA_W-1:0] o_acc_bottom
);
	typedef enum logic {div_idle, div_run} div_state_t;
	function automatic logic is_mult(input op_t op);
		is_mult = op inside {op_prod_acc, op_prod_acc_u, op_prod_accum, op_prod_accum_u,
			op_prod_sub, op_prod_sub_u, op_prod_gpr};
	endfunction : is_mult
	function automatic logic is_signed(input op_t op);
		is_signed = op inside {op_prod_acc, op_prod_accum, op_prod_sub, op_prod_gpr, op_quot};
	endfunction : is_signed
	function automatic logic is_move(input op_t op);
		is_move = op inside {op_move_upper, op_move_bottom};
	endfunction : is_move
	function automatic logic right_long(input logic [DATA_W-1:0] r, input logic s);
		right_long = s ? !((&r[DATA_W-1:HALF_W-1]) || !(|r[DATA_W-1:HALF_W-1]))
			: |r[DATA_W-1:HALF_W];
	endfunction : right_long
	function automatic logic [1:0] dvd_class(input logic [DATA_W-1:0] m);
		if (!(|m[DATA_W-1:FIT_8]))
			dvd_class = CLASS_8;
		else if (!(|m[DATA_W-1:HALF_W]))
			dvd_class = CLASS_16;
		else if (!(|m[DATA_W-1:FIT_24]))
			dvd_class = CLASS_24;
		else
			dvd_class = CLASS_32;
	endfunction : dvd_class
	logic [ACC_W-1:0] acc;
	logic pass2;
	issue_t held;
	logic signed [PROD_W-1:0] p_low;
	gpr_wr_t mul_stage;
	div_state_t div_state;
	logic [CNT_W-1:0] cnt;
	logic [CNT_W-1:0] iters;
	logic [DATA_W-1:0] quo;
	logic [DATA_W-1:0] rem;
	logic [DATA_W-1:0] dvsr;
	logic neg_q;
	logic neg_r;
	logic accept;
	logic sg_new;
	logic long_new;
	logic sg_use;
	logic signed [MCAND_W-1:0] mcand;
	logic signed [MPLIER_W-1:0] mplier;
	logic signed [PROD_W-1:0] prod;
	logic [ACC_W-1:0] prod_full;
	logic fin_valid;
	op_t fin_op;
	logic [DEST_W-1:0] fin_dest;
	logic div_done;
	logic [DATA_W-1:0] mag_l;
	logic [DATA_W-1:0] mag_r;
	logic [1:0] cls;
	logic [DATA_W:0] rem_sh;
	logic [DATA_W:0] diff;
	logic ge;
	logic [DATA_W-1:0] next_quo;
	logic [DATA_W-1:0] next_rem;
	logic [DATA_W-1:0] fix_quo;
	logic [DATA_W-1:0] fix_rem;

	assign sg_new = is_signed(i_issue.op);
	assign long_new = right_long(i_issue.right, sg_new);
	always_comb begin
		o_stall = 1'b0;
		if (i_issue_valid && i_issue.op != op_none) begin
			o_stall = pass2
				|| (div_state == div_run && !(div_done && is_move(i_issue.op)))
				|| (is_move(i_issue.op) && mul_stage.valid);
		end
	end
	assign accept = i_issue_valid && i_issue.op != op_none && !o_stall;

	// Left operand feeds 32 side, right feeds 16
	assign sg_use = pass2 ? is_signed(held.op) : sg_new;
	assign mcand = pass2 ? {sg_use & held.left[DATA_W-1], held.left}
		: {sg_use & i_issue.left[DATA_W-1], i_issue.left};
	// Low half first, high half on second pass
	always_comb begin
		if (pass2)
			mplier = {sg_use & held.right[DATA_W-1], held.right[DATA_W-1:HALF_W]};
		else if (long_new)
			mplier = {1'b0, i_issue.right[HALF_W-1:0]};
		else
			mplier = i_issue.right[MPLIER_W-1:0];
	end

	booth_array #(.AW(MCAND_W), .BW(MPLIER_W)) u_array (
		.i_mcand(mcand),
		.i_mplier(mplier),
		.o_product(prod)
	);

	always_comb begin
		prod_full = {{(ACC_W-PROD_W){prod[PROD_W-1]}}, prod};
		if (pass2)
			prod_full = ACC_W'(prod_full << HALF_W)
				+ {{(ACC_W-PROD_W){p_low[PROD_W-1]}}, p_low};
	end

	assign fin_valid = pass2 || (accept && is_mult(i_issue.op) && !long_new);
	assign fin_op = pass2 ? held.op : i_issue.op;
	assign fin_dest = pass2 ? held.dest : i_issue.dest;
	// Long multiply holds the array a second cycle
	always_ff @(posedge i_sys_clk) begin
		if (i_rst) begin
			pass2 <= 1'b0;
			held <= '0;
			p_low <= '0;
		end else begin
			pass2 <= accept && is_mult(i_issue.op) && long_new;
			if (accept && long_new) begin
				held <= i_issue;
				p_low <= prod;
			end
		end
	end

	// Accumulator updates on the finishing pass
	always_ff @(posedge i_sys_clk) begin
		if (i_rst) begin
			acc <= '0;
		end else if (div_done) begin
			acc <= {fix_rem, fix_quo};
		end else if (fin_valid) begin
			case (fin_op)
				op_prod_acc, op_prod_acc_u: acc <= prod_full;
				op_prod_accum, op_prod_accum_u: acc <= acc + prod_full;
				op_prod_sub, op_prod_sub_u: acc <= acc - prod_full;
				default: acc <= acc;
			endcase
		end
	end
	assign o_acc_upper = acc[ACC_W-1:DATA_W];
	assign o_acc_bottom = acc[DATA_W-1:0];
	// Low product bits staged to the register file
	always_ff @(posedge i_sys_clk) begin
		if (i_rst) begin
			mul_stage <= '0;
		end else begin
			mul_stage.valid <= fin_valid && fin_op == op_prod_gpr;
			mul_stage.dest <= fin_dest;
			mul_stage.data <= prod_full[DATA_W-1:0];
		end
	end

	// Move-from copies, bypassing a finishing divide
	always_ff @(posedge i_sys_clk) begin
		if (i_rst) begin
			o_gpr_wr <= '0;
		end else if (mul_stage.valid) begin
			o_gpr_wr <= mul_stage;
		end else if (accept && is_move(i_issue.op)) begin
			o_gpr_wr.valid <= 1'b1;
			o_gpr_wr.dest <= i_issue.dest;
			if (i_issue.op == op_move_upper)
				o_gpr_wr.data <= div_done ? fix_rem : acc[ACC_W-1:DATA_W];
			else
				o_gpr_wr.data <= div_done ? fix_quo : acc[DATA_W-1:0];
		end else begin
			o_gpr_wr.valid <= 1'b0;
		end
	end

	assign mag_l = (sg_new && i_issue.left[DATA_W-1]) ? DATA_W'(-i_issue.left) : i_issue.left;
	assign mag_r = (sg_new && i_issue.right[DATA_W-1]) ? DATA_W'(-i_issue.right) : i_issue.right;
	assign cls = dvd_class(mag_l);
	assign div_done = div_state == div_run && cnt == CNT_ZERO;
	// Restoring step, one bit per clock
	always_comb begin
		rem_sh = {rem, quo[DATA_W-1]};
		diff = rem_sh - {1'b0, dvsr};
		ge = rem_sh >= {1'b0, dvsr};
		next_rem = ge ? diff[DATA_W-1:0] : rem_sh[DATA_W-1:0];
		next_quo = {quo[DATA_W-2:0], ge};
		fix_quo = neg_q ? DATA_W'(-next_quo) : next_quo;
		fix_rem = neg_r ? DATA_W'(-next_rem) : next_rem;
	end

	// Runs independent of integer pipeline stalls
	always_ff @(posedge i_sys_clk) begin
		if (i_rst) begin
			div_state <= div_idle;
			cnt <= CNT_ZERO;
			iters <= CNT_ZERO;
			quo <= '0;
			rem <= '0;
			dvsr <= '0;
			neg_q <= 1'b0;
			neg_r <= 1'b0;
		end else begin
			case (div_state)
				div_idle: begin
					if (accept && i_issue.op inside {op_quot, op_quot_u}) begin
						div_state <= div_run;
						cnt <= DIV_REP[cls] - CNT_ONE;
						iters <= ITER_FULL - DIV_SKIP[cls];
						quo <= mag_l << DIV_SKIP[cls];
						rem <= '0;
						dvsr <= mag_r;
						neg_q <= sg_new && (i_issue.left[DATA_W-1] ^ i_issue.right[DATA_W-1]);
						neg_r <= sg_new && i_issue.left[DATA_W-1];
					end
				end
				div_run: begin
					if (cnt < iters) begin
						quo <= next_quo;
						rem <= next_rem;
					end
					cnt <= cnt - CNT_ONE;
					if (cnt == CNT_ZERO)
						div_state <= div_idle;
				end
				default: div_state <= div_idle;
			endcase
		end
	end

	default clocking cb @(posedge i_sys_clk); endclocking
	default disable iff (i_rst);

	chk_long_two_pass: assert property (
		accept && is_mult(i_issue.op) && long_new |=> pass2 ##1 !pass2)
		else $error("long multiply did not take exactly two passes");
	chk_short_one_pass: assert property (
		accept && is_mult(i_issue.op) && !long_new |=> !pass2)
		else $error("short multiply took a second pass");
	chk_long_back_stall: assert property (
		pass2 && i_issue_valid && is_mult(i_issue.op) |-> o_stall)
		else $error("back-to-back long multiply not stalled");
	chk_div_busy_stall: assert property (
		div_state == div_run && !div_done && i_issue_valid && i_issue.op != op_none |-> o_stall)
		else $error("issue accepted during running divide");
	chk_div_skip_count: assert property (
		accept && i_issue.op == op_quot && cls == CLASS_8 |=> iters == 6'h09)
		else $error("short dividend did not skip iterations");
	chk_div_repeat_short: assert property (
		accept && i_issue.op == op_quot_u && cls == CLASS_8
		|=> (!div_done)[*8] ##1 !div_done ##1 !div_done ##1 div_done)
		else $error("short divide busy time wrong");
	chk_acc_short_latency: assert property (
		accept && i_issue.op == op_prod_acc && !long_new |=> acc == $past(prod_full))
		else $error("accumulator not written one cycle after short multiply");
	chk_accum_add: assert property (
		accept && i_issue.op == op_prod_accum && !long_new
		|=> acc == $past(acc) + $past(prod_full))
		else $error("accumulate result wrong");
	chk_gpr_mul_latency: assert property (
		accept && i_issue.op == op_prod_gpr && !long_new
		|-> ##2 o_gpr_wr.valid && o_gpr_wr.data == $past(prod_full[DATA_W-1:0], 2))
		else $error("register multiply latency or data wrong");
	chk_move_upper_copy: assert property (
		accept && i_issue.op == op_move_upper && !div_done
		|=> o_gpr_wr.valid && o_gpr_wr.data == $past(acc[ACC_W-1:DATA_W]))
		else $error("move-from-upper copied wrong value");

	cov_short_acc: cover property (accept && i_issue.op == op_prod_accum && !long_new);
	cov_long_gpr: cover property (accept && i_issue.op == op_prod_gpr && long_new);
	cov_div_full: cover property (accept && i_issue.op == op_quot && cls == CLASS_32);
	cov_move_bypass: cover property (accept && div_done && i_issue.op == op_move_bottom);
endmodule : product_quotient_unit
`default_nettype wire

// >>> testbench/int_pipe_model.sv
`timescale 1ns/1ps
`default_nettype none
module int_pipe_model import product_quotient_pkg::*; (
	input wire logic i_sys_clk,
	input wire logic i_stall,
	output logic o_issue_valid,
	output issue_t o_issue
);
	initial begin
		o_issue_valid = 1'b0;
		o_issue = '0;
	end
	task automatic send(input issue_t ins, output int stalls);
		logic s;
		o_issue_valid = 1'b1;
		o_issue = ins;
		stalls = 0;
		s = 1'b1;
		while (s !== 1'b0 && stalls >= 0) begin
			@(negedge i_sys_clk);
			s = i_stall;
			@(posedge i_sys_clk);
			#1;
			if (s !== 1'b0) begin
				stalls = (stalls == 40) ? -1 : stalls + 1;
			end
		end
	endtask : send
	// Released lines toggle
	task automatic idle(input int n);
		o_issue_valid = 1'b0;
		o_issue.op = op_none;
		repeat (n) begin
			o_issue.left = ~o_issue.left;
			o_issue.right = ~o_issue.right;
			@(posedge i_sys_clk);
			#1;
		end
	endtask : idle
endmodule : int_pipe_model
`default_nettype wire

// >>> testbench/product_quotient_unit_tb.sv
`timescale 1ns/1ps
`default_nettype none
module product_quotient_unit_tb import product_quotient_pkg::*;;
	logic i_sys_clk = 1'b0;
	logic i_rst = 1'b1;
	logic issue_valid;
	issue_t issue;
	logic stall;
	gpr_wr_t gpr_wr;
	logic [DATA_W-1:0] acc_upper;
	logic [DATA_W-1:0] acc_bottom;
	int fails = 0;
	int checked = 0;
	logic [31:0] seed = 32'hE9F4;
	logic [ACC_W-1:0] acc_m = '0;
	logic [ACC_W-1:0] p;
	logic [31:0] x, l, r, q, rm;
	logic [4:0] d;
	logic lg, prev_lg;
	op_t op;
	op_t acc_ops [6] = '{op_prod_acc, op_prod_acc_u, op_prod_accum, op_prod_accum_u,
		op_prod_sub, op_prod_sub_u};
	logic [31:0] dvd [4] = '{32'h0000005A, 32'h00001234, 32'h00123456, 32'h12345678};
	int rep [4] = '{11, 18, 25, 32};

	product_quotient_unit product_quotient_unit_i (.i_sys_clk(i_sys_clk), .i_rst(i_rst),
		.i_issue_valid(issue_valid), .i_issue(issue), .o_stall(stall),
		.o_gpr_wr(gpr_wr), .o_acc_upper(acc_upper), .o_acc_bottom(acc_bottom));
	int_pipe_model int_pipe_model_i (.i_sys_clk(i_sys_clk), .i_stall(stall),
		.o_issue_valid(issue_valid), .o_issue(issue));

	initial begin
		forever #4 i_sys_clk = ~i_sys_clk;
	end

	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : rnd

	function automatic logic [ACC_W-1:0] prod(input op_t o, input logic [31:0] a, b);
		if (o inside {op_prod_acc, op_prod_accum, op_prod_sub, op_prod_gpr}) begin
			return {{32{a[31]}}, a} * {{32{b[31]}}, b};
		end
		return {32'h0, a} * {32'h0, b};
	endfunction : prod

	task automatic end_of_test();
		$display("checked %0d fails %0d", checked, fails);
		if (fails == 0 && checked > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : end_of_test

	task automatic check(input logic [ACC_W-1:0] got, exp, input string msg);
		checked++;
		if (got !== exp) begin
			fails++;
			$display("wrong value at %0t: %s got %h exp %h", $time, msg, got, exp);
		end
	endtask : check

	task automatic send(input op_t o, input logic [31:0] a, b, input logic [4:0] t, int exp);
		issue_t ins;
		int st;
		ins = '{op: o, left: a, right: b, dest: t};
		int_pipe_model_i.send(ins, st);
		if (st < 0) begin
			fails++;
			end_of_test();
		end else begin
			check(ACC_W'(st), ACC_W'(exp), "stall cycles");
		end
	endtask : send

	initial begin
		repeat (4) @(posedge i_sys_clk);
		#1;
		i_rst = 1'b0;
		check({acc_upper, acc_bottom}, '0, "reset acc");
		prev_lg = 1'b0;
		for (int k = 0; k < 36; k++) begin
			op = acc_ops[k % 6];
			x = rnd();
			lg = x[7];
			l = rnd();
			if (x[5]) l = l >> x[20:16];
			r = lg ? ({x[31], ~x[31], x[29:0]} | 32'h00100000) : {18'h0, x[13:0]};
			send(op, l, r, 5'h00, prev_lg ? 1 : 0);
			p = prod(op, l, r);
			case (op)
				op_prod_acc, op_prod_acc_u: acc_m = p;
				op_prod_accum, op_prod_accum_u: acc_m = acc_m + p;
				default: acc_m = acc_m - p;
			endcase
			if (!lg) check({acc_upper, acc_bottom}, acc_m, "short acc");
			prev_lg = lg;
			if (x[4]) begin
				d = x[12:8];
				send(x[6] ? op_move_upper : op_move_bottom, rnd(), rnd(), d, lg ? 1 : 0);
				check(ACC_W'({gpr_wr.valid, gpr_wr.dest, gpr_wr.data}),
					ACC_W'({1'b1, d, x[6] ? acc_m[63:32] : acc_m[31:0]}), "move");
				check({acc_upper, acc_bottom}, acc_m, "acc after move");
				prev_lg = 1'b0;
			end
		end
		$display("test multiply to acc done");
		int_pipe_model_i.idle(3);
		for (int k = 0; k < 8; k++) begin
			x = rnd();
			lg = x[3];
			l = rnd();
			r = lg ? ({x[31], ~x[31], x[29:0]} | 32'h00010000) : {18'h0, x[13:0]};
			d = x[12:8];
			p = prod(op_prod_gpr, l, r);
			send(op_prod_gpr, l, r, d, 0);
			int_pipe_model_i.idle(lg ? 1 : 0);
			check(ACC_W'(gpr_wr.valid), '0, "gpr early");
			int_pipe_model_i.idle(1);
			check(ACC_W'({gpr_wr.valid, gpr_wr.dest, gpr_wr.data}),
				ACC_W'({1'b1, d, p[31:0]}), "gpr write");
			check({acc_upper, acc_bottom}, acc_m, "acc kept");
			int_pipe_model_i.idle(1);
			check(ACC_W'(gpr_wr.valid), '0, "gpr pulse");
		end
		$display("test multiply to register done");
		for (int c = 0; c < 8; c++) begin
			x = rnd();
			l = dvd[c % 4];
			r = {24'h0, x[7:0]} | 32'h1;
			if (c >= 4 && x[0]) l = -l;
			if (c >= 4 && x[1]) r = -r;
			if (c >= 4) begin
				q = $signed(l) / $signed(r);
				rm = $signed(l) % $signed(r);
			end else begin
				q = l / r;
				rm = l % r;
			end
			d = x[12:8];
			send(c >= 4 ? op_quot : op_quot_u, l, r, 5'h00, 0);
			send(op_move_bottom, rnd(), rnd(), d, rep[c % 4] - 1);
			check(ACC_W'({gpr_wr.valid, gpr_wr.dest, gpr_wr.data}),
				ACC_W'({1'b1, d, q}), "quot");
			check({acc_upper, acc_bottom}, {rm, q}, "div acc");
		end
		$display("test divide done");
		int_pipe_model_i.idle(1);
		i_rst = 1'b1;
		int_pipe_model_i.idle(2);
		i_rst = 1'b0;
		check({acc_upper, acc_bottom}, '0, "mid reset");
		check(ACC_W'(gpr_wr.valid), '0, "mid reset write");
		l = rnd();
		r = {18'h0, l[13:0]};
		send(op_prod_acc, l, r, 5'h00, 0);
		check({acc_upper, acc_bottom}, prod(op_prod_acc, l, r), "acc after reset");
		$display("test reset done");
		end_of_test();
	end
endmodule : product_quotient_unit_tb
`default_nettype wire
